// ---- logic/gofm_pkg.sv ----
package gofm_pkg;

	// ************************************************************
	// Register map (byte addresses).
	// ************************************************************
	localparam logic [11:0] GOFM_CTRL_ADDR = 12'h000;
	localparam logic [11:0] GOFM_STATUS_ADDR = 12'h004;
	localparam logic [11:0] GOFM_PULSE_ADDR = 12'h008;
	localparam logic [11:0] GOFM_PWM_ADDR = 12'h00C;
	localparam logic [11:0] GOFM_FUNC_BASE = 12'h040;
	localparam logic [11:0] GOFM_OUT_ADDR = 12'h080;
	localparam logic [11:0] GOFM_PULSE_REQ_ADDR = 12'h084;

	// ************************************************************
	// Output count and PWM-capable outputs.
	// ************************************************************
	localparam int GOFM_NOUT = 16;
	localparam int GOFM_PWM_OUT_A = 12;
	localparam int GOFM_PWM_OUT_B = 13;

	// ************************************************************
	// Function codes.
	// ************************************************************
	localparam logic [15:0] F_NONE = 16'h0000;
	localparam logic [15:0] F_VRESET = 16'd2213;
	localparam logic [15:0] F_SPD_INC = 16'd2221;
	localparam logic [15:0] F_SPD_DEC = 16'd2222;
	localparam logic [15:0] F_SPD_RESET = 16'd2223;
	localparam logic [15:0] F_PWM = 16'd2231;
	localparam logic [15:0] F_M_OFF = 16'd3001;
	localparam logic [15:0] F_M_MAN = 16'd3002;
	localparam logic [15:0] F_M_AUTO = 16'd3003;
	localparam logic [15:0] F_M_TEST = 16'd3004;
	localparam logic [15:0] F_M_REM = 16'd3005;
	localparam logic [15:0] F_NOT_OFF = 16'd3011;
	localparam logic [15:0] F_AUTO_GRP = 16'd3012;
	localparam logic [15:0] F_BARS = 16'd3031;
	localparam logic [15:0] F_GEN_TOL = 16'd3032;
	localparam logic [15:0] F_MAINS_TOL = 16'd3033;
	localparam logic [15:0] F_PROT_OK = 16'd3034;
	localparam logic [15:0] F_RUV1 = 16'd3035;
	localparam logic [15:0] F_RUV2 = 16'd3036;
	localparam logic [15:0] F_PAR_OK = 16'd3037;
	localparam logic [15:0] F_RUN = 16'd3061;
	localparam logic [15:0] F_READY = 16'd3062;
	localparam logic [15:0] F_SYNC_GEN = 16'd3091;
	localparam logic [15:0] F_SYNC_MAINS = 16'd3092;

	// ************************************************************
	// Timing: 200 MHz clock, 500 Hz PWM, 1 ms pulse unit.
	// ************************************************************
	localparam int GOFM_CLK_HZ = 200_000_000;
	localparam int GOFM_PWM_HZ = 500;
	localparam int GOFM_PWM_PERIOD_CYC = GOFM_CLK_HZ / GOFM_PWM_HZ;
	localparam int GOFM_MS_CYC_DEF = GOFM_CLK_HZ / 1000;
	localparam logic [9:0] GOFM_PCT_FULL = 10'd100;

	// ************************************************************
	// Field positions.
	// ************************************************************
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_ENG_RUN = 4;
	localparam int CTRL_BARS = 5;
	localparam int CTRL_GEN_TOL = 6;
	localparam int CTRL_MAINS_TOL = 7;
	localparam int CTRL_MAINS_FAULT = 8;
	localparam int CTRL_RUV1 = 9;
	localparam int CTRL_RUV2 = 10;
	localparam int CTRL_PAR_OK = 11;
	localparam int CTRL_SYNC_GEN = 12;
	localparam int CTRL_SYNC_MAINS = 13;
	localparam int CTRL_PWM_VALID = 14;
	localparam int PREQ_VRESET = 0;
	localparam int PREQ_SINC = 1;
	localparam int PREQ_SDEC = 2;
	localparam int PREQ_SRESET = 3;
	localparam int PREQ_PCT_LSB = 8;

	typedef enum logic [2:0] {
		GOFM_MODE_OFF,
		GOFM_MODE_MAN,
		GOFM_MODE_AUTO,
		GOFM_MODE_TEST,
		GOFM_MODE_REMOTE
	} gofm_mode_t;

	typedef struct packed {
		logic vreset;
		logic sinc;
		logic sdec;
		logic sreset;
	} gofm_pulses_t;

endpackage : gofm_pkg

// ---- logic/gofm_top.sv ----
`timescale 1ns/1ps
// Function
// R1 - Voltage-reset function emits a regulator pulse.
// R2 - Speed up/down pulses, length bounded by percentages.
// R3 - Speed-reset function emits a nominal-speed pulse.
// R4 - PWM speed output 500 Hz, duty follows request.
// R5 - PWM allowed only on outputs twelve, thirteen.
// R6 - Five mode indicators follow current mode.
// R7 - Not-in-off asserts in manual or automatic.
// R8 - Automatic group: auto, test or remote.
// R9 - Bars-live follows bar voltage presence.
// R10 - Generator-tolerance follows normal-operation window.
// R11 - Mains-tolerance follows mains-live window.
// R12 - Protection-healthy normally on, drops on fault.
// R13 - Two outputs carry reactive-undervoltage trips.
// R14 - Parallel consent follows mains permission.
// R15 - Engine-running follows detected run, any start.
// R16 - Ready when running and pre-supply delay done.
// R17 - Generator-breaker sync indicator during its sync.
// R18 - Mains-breaker sync indicator during its sync.
// R19 - Each output selects function by code.
// R20 - Reset leaves all outputs and PWM low.
module gofm_top
	import gofm_pkg::*;
#(
	parameter int MS_CYC = GOFM_MS_CYC_DEF,
	parameter int PWM_PERIOD = GOFM_PWM_PERIOD_CYC
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ready_delay_done,
	output logic [GOFM_NOUT-1:0] dout
);

	// ************************************************************
	// Register state.
	// ************************************************************
	logic [15:0] ctrl_q;
	logic [15:0] func_q [GOFM_NOUT];
	logic [9:0] pmin_q;
	logic [9:0] pmax_q;
	logic [9:0] pwm_duty_q;
	logic [9:0] preq_pct_q;
	gofm_pulses_t preq_q;
	gofm_pulses_t pulse_q;
	logic [31:0] pcnt_q;
	logic [31:0] plen_q;
	logic [31:0] pwm_cnt_q;
	logic pwm_q;
	logic ready_q;
	logic [GOFM_NOUT-1:0] dout_d;
	logic [31:0] rdata_d;
	logic setup;
	logic wr;
	logic [3:0] widx;
	gofm_mode_t mode;

	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign widx = paddr[5:2];
	assign mode = gofm_mode_t'(ctrl_q[CTRL_MODE_LSB +: 3]);

	// Control and parameter writes; strobe bit 0 alone gates the whole word.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= 16'h0000;
			pmin_q <= 10'h000;
			pmax_q <= 10'h000;
			pwm_duty_q <= 10'h000;
		end
		else if (wr && pstrb[0])
		begin
			if (paddr == GOFM_CTRL_ADDR)
				ctrl_q <= pwdata[15:0];
			if (paddr == GOFM_PULSE_ADDR)
			begin
				pmin_q <= pwdata[9:0]; // R2
				pmax_q <= pwdata[25:16]; // R2
			end
			if (paddr == GOFM_PWM_ADDR)
				pwm_duty_q <= (pwdata[9:0] > GOFM_PCT_FULL) ? GOFM_PCT_FULL : pwdata[9:0];
		end
	end

	// Function code table; PWM code is refused outside the two capable outputs.
	generate
		for (genvar i = 0; i < GOFM_NOUT; i++)
		begin : g_func
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					func_q[i] <= F_NONE; // R19
				else if (wr && pstrb[0] && paddr[11:6] == GOFM_FUNC_BASE[11:6]
					&& widx == 4'(i))
				begin
					if (pwdata[15:0] != F_PWM || i == GOFM_PWM_OUT_A || i == GOFM_PWM_OUT_B)
						func_q[i] <= pwdata[15:0]; // R5
				end
			end
		end
	endgenerate

	// Pulse requests: software writes a one-shot request with a length percentage.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			preq_q <= '0;
			preq_pct_q <= 10'h000;
		end
		else if (wr && paddr == GOFM_PULSE_REQ_ADDR)
		begin
			preq_q.vreset <= pwdata[PREQ_VRESET];
			preq_q.sinc <= pwdata[PREQ_SINC];
			preq_q.sdec <= pwdata[PREQ_SDEC];
			preq_q.sreset <= pwdata[PREQ_SRESET];
			preq_pct_q <= pwdata[PREQ_PCT_LSB +: 10];
		end
		else
			preq_q <= '0;
	end

	// Pulse generator: the length is clamped between minimum and maximum
	// percentages of a 100 ms full scale, so a runaway request cannot hold
	// the governor input indefinitely.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pulse_q <= '0;
			pcnt_q <= 32'h0000_0000;
			plen_q <= 32'h0000_0000;
		end
		else if (preq_q != '0)
		begin
			pulse_q <= preq_q; // R1 R3
			pcnt_q <= 32'h0000_0000;
			if (preq_pct_q < pmin_q)
				plen_q <= 32'(pmin_q) * 32'(MS_CYC); // R2
			else if (preq_pct_q > pmax_q)
				plen_q <= 32'(pmax_q) * 32'(MS_CYC); // R2
			else
				plen_q <= 32'(preq_pct_q) * 32'(MS_CYC);
		end
		else if (pulse_q != '0)
		begin
			if (pcnt_q + 32'h0000_0001 >= plen_q)
				pulse_q <= '0;
			pcnt_q <= pcnt_q + 32'h0000_0001;
		end
	end

	// Free-running 500 Hz PWM; held low until a speed request is marked valid.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pwm_cnt_q <= 32'h0000_0000;
			pwm_q <= 1'b0; // R20
		end
		else
		begin
			if (pwm_cnt_q >= 32'(PWM_PERIOD - 1))
				pwm_cnt_q <= 32'h0000_0000; // R4
			else
				pwm_cnt_q <= pwm_cnt_q + 32'h0000_0001;
			pwm_q <= ctrl_q[CTRL_PWM_VALID]
				&& (pwm_cnt_q * 32'(GOFM_PCT_FULL) < 32'(pwm_duty_q) * 32'(PWM_PERIOD)); // R4
		end
	end

	// Ready needs both running and the pre-supply delay; losing either drops it.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ready_q <= 1'b0;
		else
			ready_q <= ctrl_q[CTRL_ENG_RUN] && ready_delay_done; // R16
	end

	// Per-output function selection; unknown codes leave the output inactive.
	generate
		for (genvar i = 0; i < GOFM_NOUT; i++)
		begin : g_sel
			always_comb
			begin
				unique case (func_q[i])
					F_VRESET: dout_d[i] = pulse_q.vreset; // R1
					F_SPD_INC: dout_d[i] = pulse_q.sinc; // R2
					F_SPD_DEC: dout_d[i] = pulse_q.sdec; // R2
					F_SPD_RESET: dout_d[i] = pulse_q.sreset; // R3
					F_PWM: dout_d[i] = pwm_q; // R4
					F_M_OFF: dout_d[i] = (mode == GOFM_MODE_OFF); // R6
					F_M_MAN: dout_d[i] = (mode == GOFM_MODE_MAN); // R6
					F_M_AUTO: dout_d[i] = (mode == GOFM_MODE_AUTO); // R6
					F_M_TEST: dout_d[i] = (mode == GOFM_MODE_TEST); // R6
					F_M_REM: dout_d[i] = (mode == GOFM_MODE_REMOTE); // R6
					F_NOT_OFF: dout_d[i] = (mode == GOFM_MODE_MAN) || (mode == GOFM_MODE_AUTO); // R7
					F_AUTO_GRP: dout_d[i] = (mode == GOFM_MODE_AUTO) || (mode == GOFM_MODE_TEST)
						|| (mode == GOFM_MODE_REMOTE); // R8
					F_BARS: dout_d[i] = ctrl_q[CTRL_BARS]; // R9
					F_GEN_TOL: dout_d[i] = ctrl_q[CTRL_GEN_TOL]; // R10
					F_MAINS_TOL: dout_d[i] = ctrl_q[CTRL_MAINS_TOL]; // R11
					F_PROT_OK: dout_d[i] = !ctrl_q[CTRL_MAINS_FAULT]; // R12
					F_RUV1: dout_d[i] = ctrl_q[CTRL_RUV1]; // R13
					F_RUV2: dout_d[i] = ctrl_q[CTRL_RUV2]; // R13
					F_PAR_OK: dout_d[i] = ctrl_q[CTRL_PAR_OK]; // R14
					F_RUN: dout_d[i] = ctrl_q[CTRL_ENG_RUN]; // R15
					F_READY: dout_d[i] = ready_q; // R16
					F_SYNC_GEN: dout_d[i] = ctrl_q[CTRL_SYNC_GEN]; // R17
					F_SYNC_MAINS: dout_d[i] = ctrl_q[CTRL_SYNC_MAINS]; // R18
					default: dout_d[i] = 1'b0; // R19
				endcase
			end
		end
	endgenerate

	// Registered pins so glitches from code changes never reach relays.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dout <= '0; // R20
		else
			dout <= dout_d; // R19
	end

	// Read mux; unmapped addresses read zero and flag an error.
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (paddr == GOFM_CTRL_ADDR)
			rdata_d = {16'h0000, ctrl_q};
		else if (paddr == GOFM_STATUS_ADDR)
			rdata_d = {27'h000_0000, ready_q, pulse_q};
		else if (paddr == GOFM_PULSE_ADDR)
			rdata_d = {6'h00, pmax_q, 6'h00, pmin_q};
		else if (paddr == GOFM_PWM_ADDR)
			rdata_d = {22'h00_0000, pwm_duty_q};
		else if (paddr[11:6] == GOFM_FUNC_BASE[11:6])
			rdata_d = {16'h0000, func_q[widx]};
		else if (paddr == GOFM_OUT_ADDR)
			rdata_d = {16'h0000, dout};
	end

	// APB answer: no wait state, ready and data registered from the setup phase.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setup;
			prdata <= setup ? rdata_d : 32'h0000_0000;
			pslverr <= setup && !(paddr[11:6] == GOFM_FUNC_BASE[11:6]
				|| paddr == GOFM_CTRL_ADDR || paddr == GOFM_STATUS_ADDR
				|| paddr == GOFM_PULSE_ADDR || paddr == GOFM_PWM_ADDR
				|| paddr == GOFM_OUT_ADDR || paddr == GOFM_PULSE_REQ_ADDR);
		end
	end

endmodule : gofm_top

// ---- bench/gofm_props.sv ----
`timescale 1ns/1ps
// ************************************************************
// Bus handshake and output checks.
// ************************************************************
module gofm_props
	import gofm_pkg::*;
#(
	parameter int MS_CYC = 4,
	parameter int PWM_PERIOD = 20
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ready_delay_done,
	input wire logic [GOFM_NOUT-1:0] dout
);
	// One clock domain, so the clock and reset are given once.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// A setup cycle is the only thing that may start an answer.
	logic setup;
	assign setup = psel && !penable;
	property p_rdy;
		setup |=> pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_one;
		pready |=> !pready;
	endproperty
	a_one: assert property (p_one) else $error("ready held too long");
	property p_idle;
		!psel |=> !pready;
	endproperty
	a_idle: assert property (p_idle) else $error("ready without request");
	property p_errq;
		pslverr |-> pready;
	endproperty
	a_errq: assert property (p_errq) else $error("error without ready");
	property p_err;
		setup && paddr == 12'h0F0 |=> pslverr;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_rst;
		$rose(presetn) |-> (dout == '0) [*3];
	endproperty
	a_rst: assert property (p_rst) else $error("outputs active after reset");
	property p_nrdy;
		setup && !pwrite && paddr == GOFM_STATUS_ADDR && !ready_delay_done
			&& !$past(ready_delay_done) && !$past(ready_delay_done, 2) |=> !prdata[4];
	endproperty
	a_nrdy: assert property (p_nrdy) else $error("ready before delay");
	property p_out;
		setup && !pwrite && paddr == GOFM_OUT_ADDR && $stable(dout)
			|=> prdata[15:0] == $past(dout);
	endproperty
	a_out: assert property (p_out) else $error("output readback wrong");
	c_err: cover property (pslverr);
	c_func: cover property (setup && pwrite && paddr >= GOFM_FUNC_BASE);
	c_pulse: cover property ($fell(dout[15]));
endmodule : gofm_props

// ---- bench/gofm_gov_model.sv ----
`timescale 1ns/1ps
// ************************************************************
// Governor side: measures high times on one selected output.
// ************************************************************
module gofm_gov_model
	import gofm_pkg::*;
(
	input wire logic pclk,
	input wire logic [GOFM_NOUT-1:0] dout,
	input wire logic [3:0] sel,
	output logic [15:0] width,
	output logic [7:0] count
);
	logic [15:0] run_q = '0;
	// A pulse is counted only when it ends, so a partial one is never reported early.
	always @(posedge pclk)
	begin
		if (dout[sel] === 1'b1)
			run_q <= run_q + 16'h0001;
		else if (run_q != 0)
		begin
			width <= run_q;
			count <= count + 8'h01;
			run_q <= '0;
		end
	end
	initial count = '0;
endmodule : gofm_gov_model

// ---- bench/gofm_tb_top.sv ----
`timescale 1ns/1ps
// ************************************************************
// Bench top with short counts so pulses and PWM fit the run.
// ************************************************************
module gofm_tb_top
	import gofm_pkg::*;
;
	localparam int MS = 4;
	localparam int PER = 20;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ready_delay_done = 0, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [3:0] pstrb = '0, sel = 4'hf;
	logic pready, pslverr;
	logic [GOFM_NOUT-1:0] dout;
	logic [15:0] width;
	logic [7:0] count, c0;
	int mismatches = 0, samples_checked = 0, cyc = 0, n;
	logic [15:0] codes [10] = '{F_BARS, F_GEN_TOL, F_MAINS_TOL, F_PROT_OK, F_RUV1, F_RUV2,
		F_PAR_OK, F_RUN, F_SYNC_GEN, F_SYNC_MAINS};
	int bits [10] = '{5, 6, 7, 8, 9, 10, 11, 4, 12, 13};
	gofm_top #(.MS_CYC(MS), .PWM_PERIOD(PER)) u_gofm_top (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .ready_delay_done, .dout);
	gofm_gov_model u_gofm_gov_model (.pclk, .dout, .sel, .width, .count);
	// Free-running clock and a hang guard well above the expected run.
	initial forever #2.5 pclk = ~pclk;
	always @(posedge pclk)
	begin
		if (++cyc == 20000)
		begin
			mismatches++;
			finish_test;
		end
	end
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	task chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	// One APB transfer; the request stands until pready is seen high.
	// Only the bench's cycle ceiling ends a wait for a slave that never answers.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hf;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Outputs follow a write two edges later; four gives margin.
	task look;
		repeat (4) @(posedge pclk);
		apb(0, GOFM_OUT_ADDR, 0);
	endtask : look
	task waitp;
		c0 = count;
		n = 0;
		while (count == c0 && n < 2000)
		begin
			@(posedge pclk);
			n++;
		end
		// A pulse that never ends is a fault, not a stale width to compare.
		if (n >= 2000)
		begin
			mismatches++;
			$display("BAD %0t no pulse seen", $time);
		end
	endtask : waitp
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, GOFM_OUT_ADDR, 0);
		chk(rd, 0);
		for (int i = 0; i < 7; i++)
			apb(1, GOFM_FUNC_BASE + 12'(4 * i), 32'(i < 5 ? F_M_OFF + i : F_NOT_OFF + i - 5));
		for (int m = 0; m < 5; m++)
		begin
			apb(1, GOFM_CTRL_ADDR, 32'(m));
			look;
			chk(rd & 32'h7f, (32'h1 << m) | ((m == 1 || m == 2) ? 32'h20 : 0) | (m >= 2 ? 32'h40 : 0));
		end
		$display("mode test done");
		for (int i = 0; i < 10; i++)
		begin
			apb(1, GOFM_FUNC_BASE + 12'h01c, 32'(codes[i]));
			apb(1, GOFM_CTRL_ADDR, 32'h1 << bits[i]);
			look;
			chk(32'(rd[7]), 32'(i != 3));
			apb(1, GOFM_CTRL_ADDR, 0);
			look;
			chk(32'(rd[7]), 32'(i == 3));
		end
		$display("flag test done");
		apb(1, GOFM_FUNC_BASE + 12'h01c, 32'(F_READY));
		apb(1, GOFM_CTRL_ADDR, 32'h10);
		look;
		chk(32'(rd[7]), 0);
		apb(0, GOFM_STATUS_ADDR, 0);
		chk(32'(rd[4]), 0);
		ready_delay_done <= 1'b1;
		look;
		chk(32'(rd[7]), 1);
		apb(1, GOFM_CTRL_ADDR, 0);
		look;
		chk(32'(rd[7]), 0);
		$display("ready test done");
		apb(1, GOFM_FUNC_BASE + 12'h00c, 32'(F_PWM));
		apb(0, GOFM_FUNC_BASE + 12'h00c, 0);
		chk(rd, 32'(F_M_TEST));
		apb(1, GOFM_FUNC_BASE + 12'h030, 32'(F_PWM));
		apb(0, GOFM_FUNC_BASE + 12'h030, 0);
		chk(rd, 32'(F_PWM));
		apb(1, GOFM_PWM_ADDR, 32'd25);
		look;
		chk(32'(rd[12]), 0);
		sel <= 4'd12;
		apb(1, GOFM_CTRL_ADDR, 32'h1 << CTRL_PWM_VALID);
		waitp;
		waitp;
		chk(32'(width), PER * 25 / 100);
		$display("pwm test done");
		sel <= 4'd15;
		apb(1, GOFM_PULSE_ADDR, 32'h0005_0002);
		for (int k = 0; k < 4; k++)
		begin
			apb(1, GOFM_FUNC_BASE + 12'h03c, 32'(k == 0 ? F_VRESET : F_SPD_INC + k - 1));
			apb(1, GOFM_PULSE_REQ_ADDR, ((k == 2 ? 32'h0 : 32'h9) << 8) | (32'h1 << k));
			waitp;
			chk(32'(width), (k == 2 ? 2 : 5) * MS);
		end
		apb(0, 12'h0F0, 0);
		chk(32'(err), 1);
		$display("pulse test done");
		finish_test;
	end
endmodule : gofm_tb_top
bind gofm_top gofm_props #(.MS_CYC(MS_CYC), .PWM_PERIOD(PWM_PERIOD)) u_gofm_props (.pclk,
	.presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .ready_delay_done, .dout);
